// >>> pkg/objctl_pkg.sv
package objctl_pkg;
  // Clock and timebase.
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_MS = 20;
  localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SET_W = 15;

  // Register byte offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TRAVERSE = 8'h04;
  localparam logic [7:0] REG_CLOSE_LEN = 8'h08;
  localparam logic [7:0] REG_OPEN_LEN = 8'h0c;
  localparam logic [7:0] REG_TIMEOUT = 8'h10;
  localparam logic [7:0] REG_FTRIP_LEN = 8'h14;
  localparam logic [7:0] REG_COMMAND = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1c;
  localparam logic [7:0] REG_OPEN_OK = 8'h20;
  localparam logic [7:0] REG_CLOSE_OK = 8'h24;
  localparam logic [7:0] REG_OPEN_FAIL = 8'h28;
  localparam logic [7:0] REG_CLOSE_FAIL = 8'h2c;

  // Control register fields.
  localparam int CTRL_TYPE_LSB = 0;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_READY_LSB = 3;
  localparam int CTRL_LEVEL_LSB = 5;
  localparam int CTRL_W = 7;
  // Command register fields.
  localparam int CMD_OPEN_BIT = 0;
  localparam int CMD_CLOSE_BIT = 1;
  localparam int CMD_CLEAR_BIT = 2;

  // Object types.
  localparam logic [1:0] TYPE_WITHDRAWABLE = 2'h0;
  localparam logic [1:0] TYPE_BREAKER = 2'h1;
  localparam logic [1:0] TYPE_DISC_MAIN = 2'h2;
  localparam logic [1:0] TYPE_DISC_EARTH = 2'h3;
  // Ready check modes.
  localparam logic [1:0] READY_HIGH = 2'h0;
  localparam logic [1:0] READY_LOW = 2'h1;
  localparam logic [1:0] READY_OFF = 2'h2;
  // Breaker status codes.
  localparam logic [1:0] BRK_INTERMEDIATE = 2'h0;
  localparam logic [1:0] BRK_OPEN = 2'h1;
  localparam logic [1:0] BRK_CLOSED = 2'h2;
  localparam logic [1:0] BRK_BAD = 2'h3;
  // Cart status code when the cart is not monitored.
  localparam logic [2:0] WD_NOT_IN_USE = 3'h4;
  // Access levels.
  localparam logic [1:0] LEVEL_CONFIGURATOR = 2'h2;

  // Default settings, times in ms and counts in ticks.
  localparam int TRAVERSE_DEF_MS = 200;
  localparam int PULSE_DEF_MS = 200;
  localparam int TIMEOUT_DEF_MS = 10000;
  localparam int FTRIP_DEF_MS = 200;
  localparam logic [SET_W-1:0] TRAVERSE_DEF = SET_W'(TRAVERSE_DEF_MS / TICK_MS);
  localparam logic [SET_W-1:0] PULSE_DEF = SET_W'(PULSE_DEF_MS / TICK_MS);
  localparam logic [SET_W-1:0] TIMEOUT_DEF = SET_W'(TIMEOUT_DEF_MS / TICK_MS);
  localparam logic [SET_W-1:0] FTRIP_DEF = SET_W'(FTRIP_DEF_MS / TICK_MS);
  localparam logic [CTRL_W-1:0] CTRL_DEF = {LEVEL_CONFIGURATOR, READY_OFF, 1'b0, TYPE_BREAKER};

  // Statistic counter indices.
  localparam int STAT_OPEN_OK = 0;
  localparam int STAT_CLOSE_OK = 1;
  localparam int STAT_OPEN_FAIL = 2;
  localparam int STAT_CLOSE_FAIL = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_OPENING, ST_CLOSING} ctl_state_type;
endpackage : objctl_pkg

// >>> pkg/stat_if.sv
`timescale 1ns/1ns
interface stat_if;
  logic [3:0] inc;
  logic clr;
  logic busy;
  logic [3:0][31:0] cnt;
  modport owner (output inc, output clr, input busy, input cnt);
  modport counter (input inc, input clr, output busy, output cnt);
endinterface : stat_if

// >>> rtl/stat_counters.sv
`timescale 1ns/1ns
module stat_counters (
  input wire logic sys_clk,
  input wire logic srst,
  stat_if.counter st
);
  import objctl_pkg::*;

  logic [3:0][31:0] cnt_r;
  logic busy_r;

  // Counters stop at the top instead of wrapping, so a huge count never reads as small.
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    return (v == 32'hffffffff) ? v : v + 32'h00000001;
  endfunction : sat_inc

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (st.clr) begin
          cnt_r[i] <= {31'h0, st.inc[i]};
        end else if (st.inc[i]) begin
          cnt_r[i] <= sat_inc(cnt_r[i]);
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= st.clr;
    end
  end

  assign st.cnt = cnt_r;
  assign st.busy = busy_r;

  chk_clear_zeroes: assert property (@(posedge sys_clk) disable iff (srst)
    st.clr && st.inc == 4'h0 |=> cnt_r == '0)
    else $error("statistics not cleared");
  chk_counter_saturates: assert property (@(posedge sys_clk) disable iff (srst)
    !st.clr && st.inc[0] && cnt_r[0] == 32'hffffffff |=> cnt_r[0] == 32'hffffffff)
    else $error("counter wrapped");
endmodule : stat_counters

// >>> rtl/object_control.sv
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
// What this block does
// - Four 32-bit counters of good and failed open and close requests.
// - Writing clear sets all counters to zero, or to one where a count lands in the same cycle; the clear bit returns to 0.
// - Withdrawable breaker: cart and breaker monitored, close checked for ready and sync.
// - Fixed breaker: breaker monitored and controlled with checks, cart not monitored.
// - Main disconnector indicates and controls; earthing switch only indicates.
// - Open and close go out as pulses on two separate relay drives.
// - Traverse time default 0.2 s; expiry with both inputs gives bad status.
// - Traverse expiry with neither input active gives intermediate status.
// - Close pulse at most its set length, ends early once closed.
// - Open pulse at most its set length, ends early once open.
// - No status change within the shared timeout raises an error and ends control.
// - Final trip holds for its set length after a trip, until the next close command when zero.
// - Under autoreclose, final trip only when no further reclose is expected.
// - Panel control is gated by a required access level, default configurator.
// - Separate local open and close command inputs.
// - Separate remote open and close command inputs.
// - Application open and close command inputs.
// - Breaker status codes: 0 intermediate, 1 open, 2 closed, 3 bad.
// - Remote selection ignores local commands; local selection ignores remote ones.
// - With sync check enabled, close runs only while permission is active.
// - With ready check enabled, close runs only while ready has the set polarity.
module object_control #(
  parameter int TICK_CYCLES = objctl_pkg::TICK_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic open_status_in,
  input wire logic close_status_in,
  input wire logic cart_inserted_input,
  input wire logic cart_removed_input,
  input wire logic ready_in,
  input wire logic sync_ok_in,
  input wire logic remote_selected,
  input wire logic local_open,
  input wire logic local_close,
  input wire logic remote_open,
  input wire logic remote_close,
  input wire logic app_open,
  input wire logic app_close,
  input wire logic reclose_expected,
  input wire logic [1:0] panel_access_level,
  output logic open_cmd,
  output logic close_cmd,
  output logic final_trip,
  output logic ctrl_fail_event,
  output logic [1:0] breaker_status,
  output logic [2:0] cart_status
);
  import objctl_pkg::*;

  stat_if st ();
  stat_counters u_stat (.sys_clk(sys_clk), .srst(srst), .st(st));

  logic [CTRL_W-1:0] ctrl_r;
  logic [SET_W-1:0] traverse_r, close_len_r, open_len_r, timeout_r, ftrip_len_r;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r, clear_busy_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_fire, wr_hit, rd_hit, panel_open_r, panel_close_r;
  logic [31:0] rd_val;

  function automatic logic known_reg(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= REG_CLOSE_FAIL;
  endfunction : known_reg

  function automatic logic [SET_W-1:0] put_set(input logic [SET_W-1:0] old,
                                               input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    v = {17'h0, old};
    for (int b = 0; b < 2; b++) begin
      if (s[b]) v[8*b +: 8] = d[8*b +: 8];
    end
    return v[SET_W-1:0];
  endfunction : put_set

  // The two write channels are taken in either order and held until both are in.
  assign s_axi_awready = !aw_got_r;
  assign s_axi_wready = !w_got_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign wr_hit = known_reg(awaddr_r) && awaddr_r != REG_STATUS;
  assign rd_hit = known_reg(s_axi_araddr);
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && !aw_got_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_r) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= CTRL_DEF;
      traverse_r <= TRAVERSE_DEF;
      close_len_r <= PULSE_DEF;
      open_len_r <= PULSE_DEF;
      timeout_r <= TIMEOUT_DEF;
      ftrip_len_r <= FTRIP_DEF;
    end else if (wr_fire) begin
      unique case (awaddr_r)
        REG_CTRL: if (wstrb_r[0]) ctrl_r <= wdata_r[CTRL_W-1:0];
        REG_TRAVERSE: traverse_r <= put_set(traverse_r, wdata_r, wstrb_r);
        REG_CLOSE_LEN: close_len_r <= put_set(close_len_r, wdata_r, wstrb_r);
        REG_OPEN_LEN: open_len_r <= put_set(open_len_r, wdata_r, wstrb_r);
        REG_TIMEOUT: timeout_r <= put_set(timeout_r, wdata_r, wstrb_r);
        REG_FTRIP_LEN: ftrip_len_r <= put_set(ftrip_len_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  // Panel commands and statistics clear are write strobes of the command register.
  logic cmd_wr, level_ok;
  assign cmd_wr = wr_fire && awaddr_r == REG_COMMAND && wstrb_r[0];
  assign level_ok = panel_access_level >= ctrl_r[CTRL_LEVEL_LSB +: 2];
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      panel_open_r <= 1'b0;
      panel_close_r <= 1'b0;
      clear_busy_r <= 1'b0;
    end else begin
      panel_open_r <= cmd_wr && wdata_r[CMD_OPEN_BIT] && level_ok;
      panel_close_r <= cmd_wr && wdata_r[CMD_CLOSE_BIT] && level_ok;
      if (cmd_wr && wdata_r[CMD_CLEAR_BIT]) begin
        clear_busy_r <= 1'b1;
      end else if (st.busy) begin
        clear_busy_r <= 1'b0;
      end
    end
  end
  assign st.clr = cmd_wr && wdata_r[CMD_CLEAR_BIT];

  // Timebase tick.
  logic [17:0] tick_cnt_r;
  logic tick;
  assign tick = tick_cnt_r == 18'(TICK_CYCLES - 1);
  always_ff @(posedge sys_clk) begin
    if (srst || tick) begin
      tick_cnt_r <= 18'h00000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 18'h00001;
    end
  end

  // Position decode: a lost or doubled status is shown only after the traverse time.
  logic [1:0] obj_type, brk_raw, brk_r;
  logic [SET_W-1:0] trav_cnt_r;
  logic trav_expired, is_breaker;
  assign obj_type = ctrl_r[CTRL_TYPE_LSB +: 2];
  assign is_breaker = obj_type == TYPE_WITHDRAWABLE || obj_type == TYPE_BREAKER;
  assign brk_raw = {close_status_in, open_status_in};
  assign trav_expired = trav_cnt_r >= traverse_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      brk_r <= BRK_INTERMEDIATE;
      trav_cnt_r <= '0;
    end else if (brk_raw == BRK_OPEN || brk_raw == BRK_CLOSED) begin
      brk_r <= brk_raw;
      trav_cnt_r <= '0;
    end else if (trav_expired) begin
      brk_r <= brk_raw;
    end else if (tick) begin
      trav_cnt_r <= trav_cnt_r + 1'b1;
    end
  end
  assign breaker_status = brk_r;
  // Cart position is monitored for the withdrawable type only.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cart_status <= WD_NOT_IN_USE;
    end else if (obj_type == TYPE_WITHDRAWABLE) begin
      cart_status <= {1'b0, cart_inserted_input, cart_removed_input};
    end else begin
      cart_status <= WD_NOT_IN_USE;
    end
  end

  // Command sources; a request is the rising edge of a permitted source.
  logic [1:0] src_open, src_close;
  logic [2:0] open_src_d_r, close_src_d_r;
  logic [2:0] open_src, close_src;
  logic req_open, req_close, close_ok, ready_ok, sync_ok;
  assign open_src = {app_open, remote_open && remote_selected,
                     local_open && !remote_selected};
  assign close_src = {app_close, remote_close && remote_selected,
                      local_close && !remote_selected};
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      open_src_d_r <= 3'h0;
      close_src_d_r <= 3'h0;
    end else begin
      open_src_d_r <= open_src;
      close_src_d_r <= close_src;
    end
  end
  assign src_open = {|(open_src & ~open_src_d_r), panel_open_r};
  assign src_close = {|(close_src & ~close_src_d_r), panel_close_r};
  assign req_open = |src_open && obj_type != TYPE_DISC_EARTH;
  assign req_close = |src_close && obj_type != TYPE_DISC_EARTH;
  assign ready_ok = !is_breaker || ctrl_r[CTRL_READY_LSB +: 2] == READY_OFF
                    || (ready_in ^ (ctrl_r[CTRL_READY_LSB +: 2] == READY_LOW));
  assign sync_ok = !is_breaker || !ctrl_r[CTRL_SYNC_BIT] || sync_ok_in;
  assign close_ok = ready_ok && sync_ok;

  // Operation state machine: pulse length and termination timeout run side by side.
  ctl_state_type state_r;
  logic [SET_W-1:0] pulse_cnt_r, to_cnt_r;
  logic reached, timed_out, open_done;
  assign reached = (state_r == ST_OPENING && brk_r == BRK_OPEN)
                   || (state_r == ST_CLOSING && brk_r == BRK_CLOSED);
  assign timed_out = state_r != ST_IDLE && !reached && to_cnt_r >= timeout_r;
  assign open_done = state_r == ST_OPENING && reached;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      open_cmd <= 1'b0;
      close_cmd <= 1'b0;
      pulse_cnt_r <= '0;
      to_cnt_r <= '0;
      ctrl_fail_event <= 1'b0;
    end else begin
      ctrl_fail_event <= timed_out;
      unique case (state_r)
        ST_IDLE: begin
          pulse_cnt_r <= '0;
          to_cnt_r <= '0;
          if (req_open) begin
            state_r <= ST_OPENING;
            open_cmd <= 1'b1;
          end else if (req_close && close_ok) begin
            state_r <= ST_CLOSING;
            close_cmd <= 1'b1;
          end
        end
        ST_OPENING, ST_CLOSING: begin
          if (tick) begin
            pulse_cnt_r <= pulse_cnt_r + 1'b1;
            to_cnt_r <= to_cnt_r + 1'b1;
          end
          if (reached || timed_out) begin
            state_r <= ST_IDLE;
            open_cmd <= 1'b0;
            close_cmd <= 1'b0;
          end else if (pulse_cnt_r >= open_len_r && state_r == ST_OPENING) begin
            open_cmd <= 1'b0;
          end else if (pulse_cnt_r >= close_len_r && state_r == ST_CLOSING) begin
            close_cmd <= 1'b0;
          end
        end
      endcase
    end
  end

  // Statistics strobes.
  assign st.inc[STAT_OPEN_OK] = open_done;
  assign st.inc[STAT_CLOSE_OK] = state_r == ST_CLOSING && reached;
  assign st.inc[STAT_OPEN_FAIL] = timed_out && state_r == ST_OPENING;
  assign st.inc[STAT_CLOSE_FAIL] = (timed_out && state_r == ST_CLOSING)
                                   || (state_r == ST_IDLE && !req_open && req_close && !close_ok);

  // A zero length keeps final trip on until the next close command starts.
  logic [SET_W-1:0] ftrip_cnt_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      final_trip <= 1'b0;
      ftrip_cnt_r <= '0;
    end else if (open_done && !reclose_expected) begin
      final_trip <= 1'b1;
      ftrip_cnt_r <= '0;
    end else if (close_cmd || (final_trip && ftrip_len_r != '0 && ftrip_cnt_r >= ftrip_len_r)) begin
      final_trip <= 1'b0;
    end else if (final_trip && tick) begin
      ftrip_cnt_r <= ftrip_cnt_r + 1'b1;
    end
  end

  // Register read mux.
  always_comb begin
    rd_val = 32'h00000000;
    unique case (s_axi_araddr)
      REG_CTRL: rd_val = {25'h0, ctrl_r};
      REG_TRAVERSE: rd_val = {17'h0, traverse_r};
      REG_CLOSE_LEN: rd_val = {17'h0, close_len_r};
      REG_OPEN_LEN: rd_val = {17'h0, open_len_r};
      REG_TIMEOUT: rd_val = {17'h0, timeout_r};
      REG_FTRIP_LEN: rd_val = {17'h0, ftrip_len_r};
      REG_COMMAND: rd_val = {29'h0, clear_busy_r, 2'h0};
      REG_STATUS: rd_val = {23'h0, state_r != ST_IDLE, final_trip, close_cmd, open_cmd,
                            cart_status, brk_r};
      REG_OPEN_OK: rd_val = st.cnt[STAT_OPEN_OK];
      REG_CLOSE_OK: rd_val = st.cnt[STAT_CLOSE_OK];
      REG_OPEN_FAIL: rd_val = st.cnt[STAT_OPEN_FAIL];
      REG_CLOSE_FAIL: rd_val = st.cnt[STAT_CLOSE_FAIL];
      default: rd_val = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_r) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_open_pending;
    state_r == ST_OPENING && brk_r != BRK_OPEN;
  endsequence
  sequence s_timeout_hit;
    s_open_pending ##0 to_cnt_r >= timeout_r;
  endsequence

  chk_relays_exclusive: assert property (!(open_cmd && close_cmd))
    else $error("open and close driven together");
  chk_earth_no_cmd: assert property ($rose(open_cmd) || $rose(close_cmd) |->
    $past(obj_type) != TYPE_DISC_EARTH)
    else $error("earthing switch commanded");
  chk_sync_gate: assert property ($rose(close_cmd) && $past(is_breaker)
    && $past(ctrl_r[CTRL_SYNC_BIT]) |-> $past(sync_ok_in))
    else $error("close without sync permission");
  chk_ready_gate: assert property ($rose(close_cmd) && $past(is_breaker)
    && $past(ctrl_r[CTRL_READY_LSB +: 2]) == READY_HIGH |-> $past(ready_in))
    else $error("close without ready");
  chk_open_early_end: assert property (open_cmd && state_r == ST_OPENING
    && brk_r == BRK_OPEN |=> !open_cmd && state_r == ST_IDLE)
    else $error("open pulse not ended on open status");
  chk_close_early_end: assert property (close_cmd && state_r == ST_CLOSING
    && brk_r == BRK_CLOSED |=> !close_cmd && st.cnt[STAT_CLOSE_OK] != $past(st.cnt[STAT_CLOSE_OK]))
    else $error("close pulse not ended on closed status");
  chk_open_pulse_max: assert property (open_cmd && state_r == ST_OPENING
    && pulse_cnt_r >= open_len_r |=> !open_cmd)
    else $error("open pulse too long");
  chk_timeout_event: assert property (s_timeout_hit |=> ctrl_fail_event
    && state_r == ST_IDLE && !open_cmd)
    else $error("termination timeout not handled");
  chk_bad_status: assert property (brk_raw == BRK_BAD && trav_expired
    ##1 brk_raw == BRK_BAD |-> brk_r == BRK_BAD)
    else $error("bad status not reported");
  chk_final_trip: assert property (open_done && !reclose_expected |=> final_trip)
    else $error("final trip missing");
  chk_local_ignored: assert property (remote_selected && !app_close && !remote_close
    && !panel_close_r |-> !req_close)
    else $error("local close accepted in remote");
endmodule : object_control

// >>> sim/breaker_model.sv
`timescale 1ns/1ns
module breaker_model (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic open_cmd,
  input wire logic close_cmd,
  input wire logic charged,
  input wire logic stuck,
  output logic open_status_in,
  output logic close_status_in,
  output logic ready_in,
  output logic sync_ok_in,
  output logic cart_inserted_input,
  output logic cart_removed_input
);
  logic [2:0] lag_r;
  // The contacts move some cycles after the coil is driven, so a pulse can end early.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      lag_r <= 3'h0;
      open_status_in <= 1'b0;
      close_status_in <= 1'b1;
    end else begin
      lag_r <= (open_cmd || close_cmd) ? lag_r + 3'h1 : 3'h0;
      if (lag_r == 3'h4) begin
        // A stuck mechanism closes both auxiliary contacts, which must read as bad.
        open_status_in <= open_cmd || stuck;
        close_status_in <= close_cmd || stuck;
      end
    end
  end
  assign ready_in = charged;
  assign sync_ok_in = 1'b1;
  assign cart_inserted_input = 1'b1;
  assign cart_removed_input = 1'b0;
endmodule : breaker_model

// >>> sim/tb_switchgear_object_control.sv
`timescale 1ns/1ns
module tb_switchgear_object_control;
  import objctl_pkg::*;
  logic sys_clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, charged;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, panel_access_level, breaker_status;
  logic open_status_in, close_status_in, ready_in, sync_ok_in, remote_selected, stuck;
  logic reclose_expected, open_cmd, close_cmd, final_trip, ctrl_fail_event;
  logic cart_inserted_input, cart_removed_input;
  logic [2:0] cart_status;
  // Command sources: local open, local close, remote open, remote close, app open, app close.
  logic [5:0] src;
  int n_errors = 0;
  int num_checks = 0;
  int n_fail_ev = 0;
  object_control #(.TICK_CYCLES(4)) object_control_inst (.sys_clk, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .open_status_in,
    .close_status_in, .cart_inserted_input, .cart_removed_input, .ready_in,
    .sync_ok_in, .remote_selected, .local_open(src[0]), .local_close(src[1]),
    .remote_open(src[2]), .remote_close(src[3]), .app_open(src[4]), .app_close(src[5]),
    .reclose_expected, .panel_access_level, .open_cmd, .close_cmd,
    .final_trip, .ctrl_fail_event, .breaker_status, .cart_status);
  breaker_model breaker_model_inst (.sys_clk, .srst, .open_cmd, .close_cmd, .charged, .stuck,
    .open_status_in, .close_status_in, .ready_in, .sync_ok_in, .cart_inserted_input,
    .cart_removed_input);
  // The error event stands one cycle, so it is counted on every edge rather than polled.
  always @(posedge sys_clk) begin
    if (ctrl_fail_event === 1'b1) n_fail_ev++;
  end
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask : rd
  // Raises one command source for two edges, then waits for any relay pulse to finish.
  task automatic fire(input int k);
    src <= 6'(1 << k);
    repeat (2) @(posedge sys_clk);
    src <= 6'h00;
    @(posedge sys_clk);
    while (open_cmd || close_cmd) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask : fire
  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {remote_selected, src} = 7'h00;
    {reclose_expected, charged, stuck} = 3'h0;
    panel_access_level = 2'h3;
    srst = 1'b1;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(REG_CTRL);
    cmp(d, 32'(CTRL_DEF));
    rd(REG_STATUS);
    cmp(d, 32'(BRK_CLOSED) | (32'(WD_NOT_IN_USE) << 2));
    rd(8'h40);
    cmp(32'(r), 32'(RESP_SLVERR));
    $display("reset and map test done");
    fire(0);
    cmp(32'(breaker_status), 32'(BRK_OPEN));
    cmp(32'(final_trip), 32'h1);
    rd(REG_OPEN_OK);
    cmp(d, 32'h1);
    $display("local open test done");
    wr(REG_CTRL, 32'({LEVEL_CONFIGURATOR, READY_HIGH, 1'b0, TYPE_WITHDRAWABLE}));
    wr(REG_COMMAND, 32'h2);
    repeat (4) @(posedge sys_clk);
    rd(REG_CLOSE_FAIL);
    cmp(d, 32'h1);
    cmp(32'(cart_status), 32'h2);
    $display("ready refusal test done");
    charged <= 1'b1;
    remote_selected <= 1'b1;
    fire(1);
    cmp(32'(breaker_status), 32'(BRK_OPEN));
    fire(3);
    cmp(32'(breaker_status), 32'(BRK_CLOSED));
    rd(REG_CLOSE_OK);
    cmp(d, 32'h1);
    $display("remote close test done");
    stuck <= 1'b1;
    wr(REG_TIMEOUT, 32'h14);
    fire(2);
    repeat (60) @(posedge sys_clk);
    cmp(32'(breaker_status), 32'(BRK_BAD));
    cmp(32'(n_fail_ev), 32'h1);
    rd(REG_OPEN_FAIL);
    cmp(d, 32'h1);
    stuck <= 1'b0;
    $display("stuck breaker test done");
    wr(REG_COMMAND, 32'h4);
    repeat (4) @(posedge sys_clk);
    rd(REG_OPEN_OK);
    cmp(d, 32'h0);
    rd(REG_CLOSE_FAIL);
    cmp(d, 32'h0);
    reclose_expected <= 1'b1;
    fire(4);
    cmp(32'(final_trip), 32'h0);
    rd(REG_OPEN_OK);
    cmp(d, 32'h1);
    $display("clear and application test done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    finish_test();
  end
endmodule : tb_switchgear_object_control
